//--- design/wdg_downcounter.sv
// digital watchdog: reloadable 7-bit downcounter, control register and stop gating
`timescale 1ns/1ps
`include "wdg_map.svh"

module wdg_downcounter
  import wdg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hw_activation,
  input wire logic ext_stop_ctrl,
  input wire logic nmi_pin,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic stop_instr,
  input wire logic wake_irq,
  output logic osc_halt,
  output logic wait_mode,
  output logic wdg_reset_req,
  output logic reset_pin_o,
  output logic reset_pin_oe_n
);

  // register bit 7 is counter bit 0, register bit 2 counter bit 5, bit 1 counter bit 6
  function automatic logic [6:0] reg_to_cnt(input logic [7:0] r);
    reg_to_cnt = {r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
  endfunction

  function automatic logic [7:0] cnt_to_reg(input logic [6:0] c, input logic act);
    cnt_to_reg = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], act};
  endfunction

  // nmi pin synchroniser; a new level counts once stages two and three agree
  logic nmi_s1, nmi_s2, nmi_s3, nmi_lvl;
  logic next_nmi_lvl;

  always_comb begin
    next_nmi_lvl = (nmi_s2 == nmi_s3) ? nmi_s3 : nmi_lvl;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_s3 <= 1'b0;
      nmi_lvl <= 1'b0;
    end else begin
      nmi_s1 <= nmi_pin;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      nmi_lvl <= next_nmi_lvl;
    end
  end

  logic [6:0] cnt;
  logic c_bit;
  logic active;
  logic reg_wr;
  logic tick;
  wdg_pm_t pm;
  wdg_pm_t next_pm;

  assign active = c_bit | hw_activation;
  assign reg_wr = bus_wr && (bus_addr == `WDG_REG_ADDR);

  // power mode: run, wait (clock runs) or true stop (clock halted, counter frozen)
  always_comb begin
    next_pm = pm;
    case (pm)
      WDG_PM_RUN: begin
        if (stop_instr) begin
          if (!active) begin
            next_pm = WDG_PM_STOP;
          end else if (ext_stop_ctrl && nmi_lvl) begin
            next_pm = WDG_PM_STOP;
          end else begin
            next_pm = WDG_PM_WAIT;
          end
        end
      end
      WDG_PM_WAIT, WDG_PM_STOP: begin
        if (wake_irq) begin
          next_pm = WDG_PM_RUN;
        end
      end
      default: next_pm = WDG_PM_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pm <= WDG_PM_RUN;
    end else begin
      pm <= next_pm;
    end
  end

  // the prescaler restarts on every write to the watchdog register, so a fresh activation never times out early
  wdg_prescaler u_prescaler (
    .clock(clock),
    .rstn(rstn),
    .run(pm != WDG_PM_STOP),
    .restart(reg_wr),
    .tick(tick)
  );

  logic [6:0] next_cnt;
  logic next_c_bit;
  logic next_req;
  logic [7:0] next_rdata;
  logic sw_fall;
  logic cnt_fall;

  always_comb begin
    next_cnt = cnt;
    next_c_bit = c_bit;
    sw_fall = 1'b0;
    cnt_fall = 1'b0;
    if (reg_wr) begin
      next_cnt = reg_to_cnt(bus_wdata);
      next_c_bit = c_bit | bus_wdata[`WDG_REG_C_BIT];
      sw_fall = cnt[`WDG_CNT_SR_BIT] && !bus_wdata[`WDG_REG_SR_BIT];
    end else if (tick && pm != WDG_PM_STOP) begin
      next_cnt = cnt - 7'h01;
      // reset bit falls after (period + 1) steps of 3072 cycles
      cnt_fall = active && (cnt == `WDG_CNT_SR_EDGE);
    end
    // request is held until the chip reset comes back on rstn
    next_req = wdg_reset_req | sw_fall | cnt_fall;
    next_rdata = 8'h00;
    if (bus_addr == `WDG_REG_ADDR) begin
      next_rdata = cnt_to_reg(cnt, active);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt <= `WDG_CNT_RESET;
      c_bit <= 1'b0;
      wdg_reset_req <= 1'b0;
      reset_pin_o <= 1'b0;
      reset_pin_oe_n <= 1'b1;
      bus_rdata <= 8'h00;
      osc_halt <= 1'b0;
      wait_mode <= 1'b0;
    end else begin
      cnt <= next_cnt;
      c_bit <= next_c_bit;
      wdg_reset_req <= next_req;
      reset_pin_o <= 1'b0;
      reset_pin_oe_n <= !next_req;
      bus_rdata <= next_rdata;
      osc_halt <= (next_pm == WDG_PM_STOP);
      wait_mode <= (next_pm == WDG_PM_WAIT);
    end
  end

  a_timeout_reset: assert property (@(posedge clock) disable iff (!rstn)
    (active && tick && pm != WDG_PM_STOP && !reg_wr && cnt == `WDG_CNT_SR_EDGE) |=>
      wdg_reset_req ##1 !reset_pin_oe_n)
    else $error("timeout did not raise reset");

  a_reload_safe: assert property (@(posedge clock) disable iff (!rstn)
    (reg_wr && bus_wdata[1] && !wdg_reset_req) |=> !wdg_reset_req && cnt[6])
    else $error("reload did not restart countdown");

  a_inactive_quiet: assert property (@(posedge clock) disable iff (!rstn)
    (!active && !reg_wr && !wdg_reset_req) |=> !wdg_reset_req)
    else $error("inactive watchdog caused timeout");

  a_activation_sticky: assert property (@(posedge clock) disable iff (!rstn)
    c_bit |=> c_bit)
    else $error("activation bit was cleared by a write");

  a_true_stop: assert property (@(posedge clock) disable iff (!rstn)
    (pm == WDG_PM_RUN && stop_instr && !active) |=> osc_halt && !wait_mode)
    else $error("inactive stop did not halt oscillator");

  a_hw_wait: assert property (@(posedge clock) disable iff (!rstn)
    (pm == WDG_PM_RUN && stop_instr && hw_activation && !ext_stop_ctrl) |=> wait_mode && !osc_halt)
    else $error("hardware option stop not taken as wait");

  a_pin_stop: assert property (@(posedge clock) disable iff (!rstn)
    (pm == WDG_PM_RUN && stop_instr && active && ext_stop_ctrl) |=> (osc_halt == $past(nmi_lvl)))
    else $error("pin-gated stop chose wrong mode");

  a_frozen_count: assert property (@(posedge clock) disable iff (!rstn)
    (pm == WDG_PM_STOP && !reg_wr) |=> $stable(cnt))
    else $error("counter moved while stopped");

  a_reset_value: assert property (@(posedge clock)
    $rose(rstn) |-> (cnt == `WDG_CNT_RESET && !c_bit && !wdg_reset_req))
    else $error("wrong reset value");

  a_sr_write_reset: assert property (@(posedge clock) disable iff (!rstn)
    (reg_wr && !bus_wdata[1] && cnt[6]) |=> wdg_reset_req)
    else $error("clearing reset bit did not reset");

  a_read_map: assert property (@(posedge clock) disable iff (!rstn)
    (bus_addr == `WDG_REG_ADDR && !reg_wr) |=> bus_rdata == {$past(cnt[0]), $past(cnt[1]), $past(cnt[2]),
      $past(cnt[3]), $past(cnt[4]), $past(cnt[5]), $past(cnt[6]), $past(active)})
    else $error("register read does not map counter");

  c_timeout: cover property (@(posedge clock) disable iff (!rstn) $rose(wdg_reset_req) && !$past(reg_wr));
  c_true_stop: cover property (@(posedge clock) disable iff (!rstn) $rose(osc_halt));
  c_wait: cover property (@(posedge clock) disable iff (!rstn) $fell(wait_mode));
  c_activate: cover property (@(posedge clock) disable iff (!rstn) $rose(c_bit));

endmodule // wdg_downcounter

//--- design/wdg_map.svh
// register address, reset values and timing counts of the watchdog
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

`define WDG_REG_ADDR 8'hd8
`define WDG_REG_RESET 8'hfe
`define WDG_CNT_RESET 7'h7f
`define WDG_CNT_SR_BIT 6
`define WDG_CNT_SR_EDGE 7'h40
`define WDG_REG_C_BIT 0
`define WDG_REG_SR_BIT 1
`define WDG_DIV_OSC 12
`define WDG_DIV_PRE 256
`define WDG_STEP_CYCLES (`WDG_DIV_OSC * `WDG_DIV_PRE)
`define WDG_MIN_INSTR 28

`endif

//--- design/wdg_pkg.sv
// types shared by the watchdog design files
package wdg_pkg;

  typedef enum logic [1:0] {
    WDG_PM_RUN,
    WDG_PM_WAIT,
    WDG_PM_STOP
  } wdg_pm_t;

endpackage

//--- design/wdg_prescaler.sv
// fixed divide-by-12 then divide-by-256 prescaler giving one tick per counter step
`timescale 1ns/1ps
`include "wdg_map.svh"

module wdg_prescaler
  import wdg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic restart,
  output logic tick
);

  logic [3:0] osc_div;
  logic [7:0] pre_div;
  logic [3:0] next_osc_div;
  logic [7:0] next_pre_div;
  logic next_tick;

  always_comb begin
    next_osc_div = osc_div;
    next_pre_div = pre_div;
    next_tick = 1'b0;
    if (restart) begin
      next_osc_div = 4'h0;
      next_pre_div = 8'h00;
    end else if (run) begin
      if (osc_div == 4'(`WDG_DIV_OSC - 1)) begin
        next_osc_div = 4'h0;
        if (pre_div == 8'(`WDG_DIV_PRE - 1)) begin
          next_pre_div = 8'h00;
          next_tick = 1'b1;
        end else begin
          next_pre_div = pre_div + 8'h01;
        end
      end else begin
        next_osc_div = osc_div + 4'h1;
      end
    end else begin
      // a step that lands on the stop entry is kept for the wake, so no step is lost
      next_tick = tick;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      osc_div <= 4'h0;
      pre_div <= 8'h00;
      tick <= 1'b0;
    end else begin
      osc_div <= next_osc_div;
      pre_div <= next_pre_div;
      tick <= next_tick;
    end
  end

  a_tick_spacing: assert property (@(posedge clock) disable iff (!rstn)
    (tick && run) |=> !tick [*8])
    else $error("prescaler ticks closer than a full step");

  a_restart_clears: assert property (@(posedge clock) disable iff (!rstn)
    restart |=> !tick ##1 (osc_div == 4'h1 || !$past(run) || $past(restart)))
    else $error("prescaler did not restart from zero");

endmodule // wdg_prescaler

//--- sim/wdg_cpu.sv
// cpu software model: register writes and reads, stop and wake pulses
`timescale 1ns/1ps
module wdg_cpu (
  input wire logic clock,
  output logic [7:0] bus_addr,
  output logic bus_wr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  output logic stop_instr,
  output logic wake_irq
);
  initial begin
    bus_addr = 8'h00;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
    stop_instr = 1'b0;
    wake_irq = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clock);
    bus_wr = 1'b0;
    // released data must not keep showing the written value
    bus_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    bus_addr = a;
    @(negedge clock);
    d = bus_rdata;
  endtask
  task automatic pulse(input logic s);
    @(negedge clock);
    stop_instr = s;
    wake_irq = ~s;
    @(negedge clock);
    stop_instr = 1'b0;
    wake_irq = 1'b0;
  endtask
endmodule // wdg_cpu

//--- sim/tb_top.sv
// self-checking testbench of the watchdog downcounter
`timescale 1ns/1ps
module tb_top;
  import wdg_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic hw = 1'b0;
  logic ext = 1'b0;
  logic nmi = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, stp, wake, halt, wt, req, pin_o, oe_n;
  int bad_count = 0;
  int cmp_count = 0;
  always #2.5 clock = ~clock;
  wdg_downcounter wdg_downcounter_i (.clock(clock), .rstn(rstn), .hw_activation(hw), .ext_stop_ctrl(ext),
    .nmi_pin(nmi), .bus_addr(addr), .bus_wr(wr), .bus_wdata(wdata), .bus_rdata(rdata), .stop_instr(stp),
    .wake_irq(wake), .osc_halt(halt), .wait_mode(wt), .wdg_reset_req(req), .reset_pin_o(pin_o),
    .reset_pin_oe_n(oe_n));
  wdg_cpu wdg_cpu_i (.clock(clock), .bus_addr(addr), .bus_wr(wr), .bus_wdata(wdata), .bus_rdata(rdata),
    .stop_instr(stp), .wake_irq(wake));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    wdg_cpu_i.rd(a, d);
    chk("rdata", d, e);
  endtask
  task automatic boot(input logic h, input logic x, input logic n);
    @(negedge clock);
    rstn = 1'b0;
    hw = h;
    ext = x;
    nmi = n;
    cyc(3);
    rstn = 1'b1;
  endtask
  task automatic t_reset();
    boot(0, 0, 0);
    chk("oe_n", oe_n, 1);
    rdchk(8'hd8, 8'hfe);
    rdchk(8'hd9, 8'h00);
    boot(1, 0, 0);
    rdchk(8'hd8, 8'hff);
  endtask
  task automatic t_swrst();
    boot(0, 0, 0);
    wdg_cpu_i.wr(8'hd8, 8'hfc);
    cyc(2);
    chk("req", req, 1);
    chk("oe_n", oe_n, 0);
    chk("pin", pin_o, 0);
  endtask
  task automatic t_timer();
    boot(0, 0, 0);
    wdg_cpu_i.wr(8'hd8, 8'h02);
    cyc(3060);
    rdchk(8'hd8, 8'h02);
    cyc(30);
    rdchk(8'hd8, 8'hfc);
    chk("req", req, 0);
  endtask
  task automatic t_timeout();
    boot(0, 0, 0);
    wdg_cpu_i.wr(8'hd8, 8'h03);
    cyc(28);
    chk("req", req, 0);
    wdg_cpu_i.wr(8'hd8, 8'h02);
    rdchk(8'hd8, 8'h03);
    cyc(3060);
    chk("req", req, 0);
    cyc(30);
    chk("req", req, 1);
    chk("oe_n", oe_n, 0);
  endtask
  task automatic t_reload();
    boot(0, 0, 0);
    wdg_cpu_i.wr(8'hd8, 8'h03);
    cyc(2000);
    wdg_cpu_i.wr(8'hd8, 8'h03);
    cyc(2000);
    chk("req", req, 0);
    cyc(1100);
    chk("req", req, 1);
  endtask
  task automatic t_stop();
    boot(0, 0, 0);
    wdg_cpu_i.pulse(1);
    cyc(1);
    chk("halt", halt, 1);
    wdg_cpu_i.pulse(0);
    cyc(1);
    chk("halt", halt, 0);
    boot(1, 0, 1);
    wdg_cpu_i.wr(8'hd8, 8'h03);
    wdg_cpu_i.pulse(1);
    cyc(1);
    chk("wait", wt, 1);
    chk("halt", halt, 0);
    cyc(3100);
    chk("req", req, 1);
    boot(1, 1, 0);
    cyc(8);
    wdg_cpu_i.pulse(1);
    cyc(1);
    chk("wait", wt, 1);
    wdg_cpu_i.pulse(0);
    nmi = 1'b1;
    cyc(8);
    wdg_cpu_i.wr(8'hd8, 8'h03);
    wdg_cpu_i.pulse(1);
    cyc(1);
    chk("halt", halt, 1);
    cyc(4000);
    chk("req", req, 0);
    wdg_cpu_i.pulse(0);
    cyc(1);
    chk("req", req, 0);
    cyc(3100);
    chk("req", req, 1);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // the whole run needs about 22k cycles
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end
  initial begin
    t_reset();
    t_swrst();
    t_timer();
    t_timeout();
    t_reload();
    t_stop();
    end_of_test();
  end
endmodule // tb_top
